// [flash_bus_pkg.sv]
package flash_bus_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // Bus timing figures, in ns
  localparam int ADDR_SETUP_NS = 100;
  localparam int ACCESS_NS = 200;
  localparam int STROBE_NS = 200;
  localparam int RECOVER_NS = 100;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_HOLD_NS = 200;
  // Least times round up to whole cycles
  localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // Bank is selected by the top address bits
  localparam int BANK_LSB = 20;
  localparam int BANK_W = 2;

  typedef enum logic [1:0]
  {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_RESET = 2'h2,
    OP_IDLE = 2'h3
  } op_t;

  // Levels on the protect/boost pin: low, high, boost voltage
  typedef enum logic [1:0]
  {
    PROT_LOW = 2'h0,
    PROT_HIGH = 2'h1,
    PROT_BOOST = 2'h2
  } prot_t;

  typedef struct packed
  {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic byte_mode;
  } req_t;

  typedef struct packed
  {
    logic [DATA_W-1:0] rdata;
    logic [BANK_W-1:0] bank;
    logic done;
  } rsp_t;

  typedef struct packed
  {
    logic chip_select_n;
    logic output_gate_n;
    logic write_strobe_n;
    logic hw_reset_n;
    logic width_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
    prot_t prot_level;
  } pins_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_RECOVER = 3'h2,
    ST_RESET = 3'h6,
    ST_RESET_HOLD = 3'h7
  } state_t;

endpackage

// [in_sync3.sv]
`timescale 1ns/1ps
// Three-stage synchroniser; output moves only when stages two and three agree
module in_sync3
  import flash_bus_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st_ff;
  sync_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.q;

endmodule

// [flash_bus_host.sv]
`timescale 1ns/1ps
// Behaviour
// [R1] Read: chip select and output gate low, write strobe high, address valid.
// [R2] Command write: write strobe and chip select low, output gate high.
// [R3] Device command register has no address; host only issues write cycles.
// [R4] Width select high gives sixteen-bit word transfers.
// [R5] Width select low: low byte only, bit 15 carries the byte address LSB.
// [R6] Word mode uses address 21..0; byte mode adds the byte LSB below. Here address bit 0 is reused as that byte LSB on dq15.
// [R7] Width select decides byte or word read data and program data.
// [R8] After reset the device reads array data without any command.
// [R9] Each bank stays in array read until a command changes it.
// [R10] Fast program mode needs two write cycles per program, not four.
// [R11] Erase covers one sector, several sectors, or the whole device.
// [R12] Four banks, each picked by its bank address bits.
// [R13] Boost voltage on protect pin enters fast program and unprotects all.
// [R14] Host applies boost only for accelerated programming; pin never floats.
// [R15] Protect pin low keeps boot sectors protected; high follows last setting.
// [R16] After id command, reads return identification codes on sixteen lines.
// [R17] Array reads in one bank may run while another bank programs.
// [R18] Suspended erase allows access within the bank except the erased sector.
// [R19] Output gate high makes the device release its data pins.
// [R20] Hardware reset low aborts operations, floats outputs, returns to read.
module flash_bus_host
  import flash_bus_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire req_t req_i,
  input wire logic boost_en_i,
  input wire logic protect_en_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic req_ready_o,
  output rsp_t rsp_o,
  output pins_t pins_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed
  {
    state_t state;
    logic [CNT_W-1:0] cnt;
    req_t cur;
    logic ready;
    rsp_t rsp;
    pins_t pins;
  } host_t;

  host_t st_ff;
  host_t nxt_st;
  logic [DATA_W-1:0] dq_sync;

  // Data pins come from the device's own timing, so they are synchronised
  in_sync3 #(.W(DATA_W)) u_dq_sync
  (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(dq_i),
    .q_o(dq_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rsp.done = 1'b0;
    nxt_st.ready = 1'b0;
    // Reset pin stays released except during host reset and while a pulse is being timed
    if (st_ff.state != ST_RESET)
    begin
      nxt_st.pins.hw_reset_n = 1'b1; // [R20]
    end
    // Boost only while the user asks for accelerated programming
    if (boost_en_i)
    begin
      nxt_st.pins.prot_level = PROT_BOOST; // [R13] [R14]
    end
    else if (protect_en_i)
    begin
      nxt_st.pins.prot_level = PROT_LOW; // [R15]
    end
    else
    begin
      nxt_st.pins.prot_level = PROT_HIGH; // [R15]
    end
    case (st_ff.state)
      ST_IDLE:
      begin
        nxt_st.ready = 1'b1;
        if (req_valid_i && st_ff.ready)
        begin
          nxt_st.ready = 1'b0;
          nxt_st.cur = req_i;
          nxt_st.cnt = CNT_W'(SETUP_CYC);
          if (req_i.op == OP_RESET)
          begin
            nxt_st.pins.hw_reset_n = 1'b0; // [R20]
            nxt_st.pins.chip_select_n = 1'b1;
            nxt_st.pins.output_gate_n = 1'b1;
            nxt_st.pins.write_strobe_n = 1'b1;
            nxt_st.cnt = CNT_W'(RESET_PULSE_CYC);
            nxt_st.state = ST_RESET;
          end
          else if (req_i.op == OP_IDLE)
          begin
            nxt_st.rsp.done = 1'b1;
            nxt_st.ready = 1'b1;
          end
          else
          begin
            nxt_st.pins.width_select_n = !req_i.byte_mode; // [R4] [R5] [R7]
            nxt_st.pins.addr = req_i.addr; // [R6]
            nxt_st.pins.chip_select_n = 1'b0;
            nxt_st.pins.output_gate_n = 1'b1;
            nxt_st.pins.write_strobe_n = 1'b1;
            nxt_st.rsp.bank = req_i.addr[BANK_LSB +: BANK_W]; // [R12] [R17]
            if (req_i.op == OP_WRITE)
            begin
              // Byte mode: dq15 is the byte address LSB, dq14..8 released
              if (req_i.byte_mode)
              begin
                nxt_st.pins.dq_out = {req_i.addr[0], 7'h00, req_i.wdata[7:0]}; // [R5]
                nxt_st.pins.dq_oe = 16'h80ff; // [R5]
              end
              else
              begin
                nxt_st.pins.dq_out = req_i.wdata; // [R4]
                nxt_st.pins.dq_oe = 16'hffff;
              end
            end
            else if (req_i.byte_mode)
            begin
              // Read in byte mode still drives the byte LSB on dq15
              nxt_st.pins.dq_out = {req_i.addr[0], 15'h0000}; // [R5] [R6]
              nxt_st.pins.dq_oe = 16'h8000;
            end
            else
            begin
              nxt_st.pins.dq_oe = 16'h0000; // [R19]
            end
            nxt_st.state = ST_SETUP;
          end
        end
      end
      ST_SETUP:
      begin
        if (st_ff.cnt <= CNT_W'(1))
        begin
          if (st_ff.cur.op == OP_WRITE)
          begin
            nxt_st.pins.write_strobe_n = 1'b0; // [R2] [R3] [R10] [R11] [R18]
            nxt_st.cnt = CNT_W'(STROBE_CYC);
          end
          else
          begin
            nxt_st.pins.output_gate_n = 1'b0; // [R1] [R8] [R9] [R16]
            // Extra cycles cover the three-stage input synchroniser
            nxt_st.cnt = CNT_W'(ACCESS_CYC + 3);
          end
          nxt_st.state = ST_STROBE;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
      end
      ST_STROBE:
      begin
        if (st_ff.cnt <= CNT_W'(1))
        begin
          if (st_ff.cur.op == OP_READ)
          begin
            // Byte reads return the low byte only; dq14..8 float
            nxt_st.rsp.rdata = st_ff.cur.byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync; // [R7]
          end
          nxt_st.pins.write_strobe_n = 1'b1;
          nxt_st.pins.output_gate_n = 1'b1; // [R19]
          nxt_st.cnt = CNT_W'(RECOVER_CYC);
          nxt_st.state = ST_RECOVER;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
      end
      ST_RECOVER:
      begin
        // Data held one more step so the write data meets hold time
        nxt_st.pins.dq_oe = 16'h0000;
        if (st_ff.cnt <= CNT_W'(1))
        begin
          nxt_st.pins.chip_select_n = 1'b1;
          nxt_st.rsp.done = 1'b1;
          nxt_st.ready = 1'b1;
          nxt_st.state = ST_IDLE;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
      end
      ST_RESET:
      begin
        if (st_ff.cnt <= CNT_W'(1))
        begin
          nxt_st.pins.hw_reset_n = 1'b1;
          nxt_st.cnt = CNT_W'(RESET_HOLD_CYC);
          nxt_st.state = ST_RESET_HOLD;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
      end
      ST_RESET_HOLD:
      begin
        // No access until the device has left reset
        if (st_ff.cnt <= CNT_W'(1))
        begin
          nxt_st.rsp.done = 1'b1;
          nxt_st.ready = 1'b1;
          nxt_st.state = ST_IDLE;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1);
        end
      end
      default:
      begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.pins.chip_select_n <= 1'b1;
      st_ff.pins.output_gate_n <= 1'b1;
      st_ff.pins.write_strobe_n <= 1'b1;
      st_ff.pins.hw_reset_n <= 1'b0;
      st_ff.pins.width_select_n <= 1'b1;
      st_ff.pins.prot_level <= PROT_LOW;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready_o = st_ff.ready;
  assign rsp_o = st_ff.rsp;
  assign pins_o = st_ff.pins;

endmodule

// [flash_dev_model.sv]
`timescale 1ns/1ps
module flash_dev_model
  import flash_bus_pkg::*;
#(
  parameter logic [15:0] ID_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_CMD = 16'h0090,
  parameter logic [15:0] EXIT_CMD = 16'h00f0,
  parameter logic [15:0] PRG_CMD = 16'h00a0
)
(
  input wire pins_t pins_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_en_o
);
  logic id_mode = 1'b0;
  logic prg_arm = 1'b0;
  logic [21:0] p_addr = '1;
  logic [15:0] p_data = 16'h0000;
  logic [15:0] word;
  wire rd = !pins_i.chip_select_n && !pins_i.output_gate_n && pins_i.write_strobe_n
    && pins_i.hw_reset_n;
  // Array is a fixed pattern so only the one programmed word needs storage
  function automatic logic [15:0] arr(input logic [21:0] x);
    return x[15:0] ^ {x[21:16], 10'h2a5};
  endfunction
  // Command latch has no address of its own; the rising strobe takes it
  always @(posedge pins_i.write_strobe_n)
  begin
    if (!pins_i.chip_select_n && pins_i.output_gate_n && pins_i.hw_reset_n)
    begin
      if (prg_arm)
      begin
        p_addr <= pins_i.addr;
        p_data <= dq_i;
      end
      prg_arm <= pins_i.prot_level == PROT_BOOST && dq_i == PRG_CMD && !prg_arm;
      id_mode <= dq_i == ID_CMD || (id_mode && dq_i != EXIT_CMD);
    end
  end
  always @(negedge pins_i.hw_reset_n)
  begin
    id_mode <= 1'b0;
    prg_arm <= 1'b0;
  end
  assign word = id_mode ? ID_CODE : pins_i.addr == p_addr ? p_data : arr(pins_i.addr);
  assign dq_en_o = !rd ? 16'h0000 : pins_i.width_select_n ? 16'hffff : 16'h00ff;
  assign dq_o = pins_i.width_select_n ? word
    : {8'h00, dq_i[15] ? word[15:8] : word[7:0]};
endmodule

// [flash_bus_props.sv]
`timescale 1ns/1ps
module flash_bus_props
  import flash_bus_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire req_t req_i,
  input wire logic boost_en_i,
  input wire logic protect_en_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic req_ready_o,
  input wire rsp_t rsp_o,
  input wire pins_t pins_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////
  sequence s_strobe;
    !pins_o.write_strobe_n [*2] ##1 pins_o.write_strobe_n;
  endsequence
  sequence s_rst_take;
    req_valid_i && req_ready_o && req_i.op == OP_RESET;
  endsequence
  sequence s_rst_pulse;
    !pins_o.hw_reset_n [*5] ##1 pins_o.hw_reset_n;
  endsequence
  chk_read_levels:
    assert property (!pins_o.chip_select_n && !pins_o.output_gate_n |-> pins_o.write_strobe_n)
    else $error("read with strobe low");
  chk_write_levels:
    assert property (!pins_o.write_strobe_n |-> !pins_o.chip_select_n && pins_o.output_gate_n)
    else $error("write levels wrong");
  chk_strobe_len:
    assert property ($fell(pins_o.write_strobe_n) |-> s_strobe)
    else $error("strobe length wrong");
  chk_no_clash:
    assert property (!pins_o.output_gate_n |->
      pins_o.dq_oe == (pins_o.width_select_n ? 16'h0000 : 16'h8000))
    else $error("host drives during read");
  chk_byte_float:
    assert property (!pins_o.width_select_n |-> pins_o.dq_oe[14:8] == 7'h00)
    else $error("upper byte driven");
  chk_boost_pin:
    assert property (boost_en_i |=> pins_o.prot_level == PROT_BOOST)
    else $error("boost level missing");
  chk_protect_pin:
    assert property (protect_en_i && !boost_en_i |=> pins_o.prot_level == PROT_LOW)
    else $error("protect level wrong");
  chk_reset_pulse:
    assert property (s_rst_take |=> s_rst_pulse)
    else $error("reset pulse wrong");
endmodule
bind flash_bus_host flash_bus_props chk_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .boost_en_i(boost_en_i),
  .protect_en_i(protect_en_i), .dq_i(dq_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o),
  .pins_o(pins_o));

// [flash_bus_host_bench.sv]
`timescale 1ns/1ps
module flash_bus_host_bench
  import flash_bus_pkg::*;
;
  localparam logic [15:0] ID_CODE = 16'h3c5a; // Arbitrary value
  localparam logic [15:0] ID_CMD = 16'h0090;
  localparam logic [15:0] PRG_CMD = 16'h00a0;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic valid = 1'b0;
  logic boost = 1'b0;
  logic prot = 1'b0;
  req_t req = '0;
  logic ready;
  rsp_t rsp;
  pins_t pins;
  logic [15:0] bus;
  logic [15:0] dev_q;
  logic [15:0] dev_en;
  logic [15:0] flt = 16'h5a5a;
  logic [31:0] rs = 32'h5922dd33;
  logic [21:0] a;
  logic bm;
  int fails = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  // Released lines flip every cycle so a stale value cannot pass
  always @(posedge clk) flt <= ~flt;
  assign bus = (pins.dq_oe & pins.dq_out) | (dev_en & dev_q) | (~(pins.dq_oe | dev_en) & flt);
  flash_bus_host dut_u (.sys_clk_i(clk), .arst_n_i(arst_n), .req_valid_i(valid), .req_i(req),
    .boost_en_i(boost), .protect_en_i(prot), .dq_i(bus), .req_ready_o(ready), .rsp_o(rsp),
    .pins_o(pins));
  flash_dev_model #(.ID_CODE(ID_CODE), .ID_CMD(ID_CMD), .PRG_CMD(PRG_CMD)) dev_u
    (.pins_i(pins), .dq_i(bus), .dq_o(dev_q), .dq_en_o(dev_en));
  ////////////////////////////////////////
  function automatic logic [15:0] exp_rd(input logic [21:0] x, input logic b);
    logic [15:0] w;
    w = x[15:0] ^ {x[21:16], 10'h2a5};
    return b ? {8'h00, x[0] ? w[15:8] : w[7:0]} : w;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report;
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bank(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, presented for one cycle once ready is high, then a bounded wait for done
  task automatic run(input op_t op, input logic [21:0] x, input logic [15:0] d, input logic b);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    req = '{op: op, addr: x, wdata: d, byte_mode: b};
    valid = 1'b1;
    @(negedge clk) valid = 1'b0;
    while (rsp.done !== 1'b1 && n < 80)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 80)
      fails++;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    a = 22'h2a1235;
    run(OP_READ, a, 16'h0000, 1'b0);
    cmp_data(rsp.rdata, exp_rd(a, 1'b0));
    repeat (40)
    begin
      rs = lfsr(rs);
      a = rs[21:0];
      bm = rs[22];
      @(negedge clk) prot = rs[23];
      // Low byte 3c never forms a command, so random writes stay harmless
      run(rs[24] ? OP_WRITE : OP_READ, a, {rs[31:24], 8'h3c}, bm);
      if (!rs[24])
      begin
        cmp_data(rsp.rdata, exp_rd(a, bm));
        cmp_bank(rsp.bank, a[21:20]);
      end
    end
    a = 22'h1f0040;
    run(OP_WRITE, a, ID_CMD, 1'b0);
    run(OP_READ, a, 16'h0000, 1'b0);
    cmp_data(rsp.rdata, ID_CODE);
    run(OP_READ, 22'h3fff00, 16'h0000, 1'b0);
    cmp_data(rsp.rdata, ID_CODE);
    run(OP_WRITE, a, 16'h00f0, 1'b0);
    run(OP_READ, a, 16'h0000, 1'b0);
    cmp_data(rsp.rdata, exp_rd(a, 1'b0));
    run(OP_WRITE, a, ID_CMD, 1'b0);
    run(OP_RESET, a, 16'h0000, 1'b0);
    run(OP_READ, a, 16'h0000, 1'b0);
    cmp_data(rsp.rdata, exp_rd(a, 1'b0));
    @(negedge clk) boost = 1'b1;
    run(OP_WRITE, a, PRG_CMD, 1'b0);
    run(OP_WRITE, a, 16'hbeef, 1'b0);
    run(OP_READ, a, 16'h0000, 1'b0);
    cmp_data(rsp.rdata, 16'hbeef);
    @(negedge clk) boost = 1'b0;
    run(OP_IDLE, a, 16'h0000, 1'b0);
    final_report;
  end
  // 53 requests of at most 12 cycles; 2 ms leaves wide margin
  initial
  begin
    #2000000;
    fails++;
    final_report;
  end
endmodule
